// [io_lines_pkg.sv]
/*
 * Package for the dual-bank I/O line block: register offsets, reset
 * values, pad control carrier and per-bank setup register bundle.
 * Assumes an 8-bit data-space bus with byte addresses and one core clock.
 */
package io_lines_pkg;

    localparam int BANK_WIDTH = 8;

    // data-space byte addresses
    localparam logic [7:0] ADDR_BANK_A_LEVEL = 8'hC0;
    localparam logic [7:0] ADDR_BANK_B_LEVEL = 8'hC1;
    localparam logic [7:0] ADDR_BANK_A_DIRECTION = 8'hC4;
    localparam logic [7:0] ADDR_BANK_B_DIRECTION = 8'hC5;
    localparam logic [7:0] ADDR_BANK_A_CONFIG = 8'hCC;
    localparam logic [7:0] ADDR_BANK_B_CONFIG = 8'hCD;

    // values after reset
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // synchroniser depth on pin inputs
    localparam int SYNC_STAGES = 2;

    // per-bank pad controls, bit n belongs to line n
    typedef struct packed {
        logic [7:0] drive_en;   // pad output buffer enabled
        logic [7:0] drive_val;  // value on the output buffer
        logic [7:0] pull_up;    // weak pull-up on
        logic [7:0] analog;     // analog switch closed
        logic [7:0] irq_en;     // line feeds the interrupt system
    } pad_ctrl_type;

    // per-bank setup bits
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] direction;
        logic [7:0] config_bits;
    } bank_regs_type;

endpackage

// [line_bank_decode.sv]
/*
 * Per-line mode decode for one byte-wide bank: turns the three setup bits
 * of each line into pad controls.
 * Assumes the caller registers the result if a flopped output is needed.
 */
`timescale 1ns/1ps

module line_bank_decode #(
    parameter logic [7:0] ANALOG_CAPABLE = 8'hFF  // lines wired to the analog mux
) (
    input wire io_lines_pkg::bank_regs_type regs,    // latch, direction, config
    output io_lines_pkg::pad_ctrl_type pad           // decoded pad controls
);
    import io_lines_pkg::*;

    genvar n;
    generate
        for (n = 0; n < BANK_WIDTH; n++) begin : g_line
            logic dir_b;
            logic cfg_b;
            logic lat_b;
            assign dir_b = regs.direction[n];
            assign cfg_b = regs.config_bits[n];
            assign lat_b = regs.level[n];
            // push-pull drives both levels; open-drain only sinks on a low latch
            assign pad.drive_en[n] = dir_b & (cfg_b | ~lat_b);
            assign pad.drive_val[n] = dir_b & cfg_b & lat_b;
            // pull-up only in the two input modes with a low latch
            assign pad.pull_up[n] = ~dir_b & ~lat_b;
            assign pad.analog[n] = ~dir_b & cfg_b & lat_b & ANALOG_CAPABLE[n];
            assign pad.irq_en[n] = ~dir_b & cfg_b & ~lat_b;
        end
    endgenerate

endmodule

// [dual_bank_io_lines.sv]
/*
 * Two byte-wide banks of general-purpose lines with level latch,
 * direction and configuration registers in data space, pad controls,
 * analog-select lines and two interrupt sources.
 * Assumes a single-cycle data-space bus on ref_clk; pins are asynchronous
 * and are synchronised here. Trigger-mode bits come from the core, which
 * also latches edge requests; this block only flags them. Software must
 * keep at most one analog line selected, nothing here blocks a second.
 */
`timescale 1ns/1ps

// Behaviour
// - three registers per bank, one bit per line
// - input lines read back live pin level
// - level latch write always stores the value
// - reset clears all registers, pull-up inputs
// - 000 gives input with pull-up
// - 001 gives high-impedance input
// - 010 gives pull-up input with interrupt
// - 011 connects line to analog mux
// - direction 1 config 0: open-drain output
// - direction 1 config 1: push-pull output
// - interrupt lines feed per-bank trigger logic
// - level_edge_select: source 1 level or falling
// - edge_polarity_select: source 2 rising or falling
module dual_bank_io_lines #(
    parameter logic [7:0] BANK_A_PRESENT = 8'hFF,  // implemented lines of bank a
    parameter logic [7:0] BANK_B_PRESENT = 8'hFF,  // implemented lines of bank b
    parameter logic [7:0] BANK_A_ANALOG = 8'h00,   // bank a lines with analog path
    parameter logic [7:0] BANK_B_ANALOG = 8'hFF    // bank b lines with analog path
) (
    input wire logic ref_clk,                      // core clock, 20 MHz
    input wire logic rst,                          // asynchronous reset, active high
    input wire logic [7:0] bus_addr,               // data-space byte address
    input wire logic bus_wr,                       // write strobe, one cycle
    input wire logic bus_rd,                       // read strobe, one cycle
    input wire logic [7:0] bus_wdata,              // write data
    output logic [7:0] bus_rdata,                  // read data, cycle after bus_rd
    input wire logic level_edge_select,            // source 1: 1 level, 0 falling edge
    input wire logic edge_polarity_select,         // source 2: 1 rising, 0 falling
    input wire logic [7:0] bank_a_pin_in,          // bank a pad input levels
    input wire logic [7:0] bank_b_pin_in,          // bank b pad input levels
    output io_lines_pkg::pad_ctrl_type bank_a_pad, // bank a pad controls
    output io_lines_pkg::pad_ctrl_type bank_b_pad, // bank b pad controls
    output logic irq_source1,                      // bank a request to interrupt system
    output logic irq_source2                       // bank b request to interrupt system
);
    import io_lines_pkg::*;

    bank_regs_type bank_a_r;
    bank_regs_type bank_a_nxt;
    bank_regs_type bank_b_r;
    bank_regs_type bank_b_nxt;
    pad_ctrl_type pad_a_nxt;
    pad_ctrl_type pad_b_nxt;
    pad_ctrl_type pad_a_r;
    pad_ctrl_type pad_b_r;

    // synchronisers and previous level for edge detection
    logic [7:0] sync_a_meta_r;
    logic [7:0] sync_a_r;
    logic [7:0] prev_a_r;
    logic [7:0] sync_b_meta_r;
    logic [7:0] sync_b_r;
    logic [7:0] prev_b_r;

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic irq1_r;
    logic irq1_nxt;
    logic irq2_r;
    logic irq2_nxt;

    // register writes; unimplemented lines stay at zero
    // unmapped addresses fall through to the default and change nothing
    always_comb begin
        bank_a_nxt = bank_a_r;
        bank_b_nxt = bank_b_r;
        if (bus_wr) begin
            case (bus_addr)
                ADDR_BANK_A_LEVEL: begin
                    bank_a_nxt.level = bus_wdata & BANK_A_PRESENT;
                end
                ADDR_BANK_B_LEVEL: begin
                    bank_b_nxt.level = bus_wdata & BANK_B_PRESENT;
                end
                ADDR_BANK_A_DIRECTION: begin
                    bank_a_nxt.direction = bus_wdata & BANK_A_PRESENT;
                end
                ADDR_BANK_B_DIRECTION: begin
                    bank_b_nxt.direction = bus_wdata & BANK_B_PRESENT;
                end
                ADDR_BANK_A_CONFIG: begin
                    bank_a_nxt.config_bits = bus_wdata & BANK_A_PRESENT;
                end
                ADDR_BANK_B_CONFIG: begin
                    bank_b_nxt.config_bits = bus_wdata & BANK_B_PRESENT;
                end
                default: begin
                    bank_a_nxt = bank_a_r;
                end
            endcase
        end
    end

    // decode from next values so flopped pads track the registers exactly
    line_bank_decode #(
        .ANALOG_CAPABLE(BANK_A_ANALOG)
    ) u_decode_a (
        .regs(bank_a_nxt),
        .pad(pad_a_nxt)
    );

    line_bank_decode #(
        .ANALOG_CAPABLE(BANK_B_ANALOG)
    ) u_decode_b (
        .regs(bank_b_nxt),
        .pad(pad_b_nxt)
    );

    // level registers as software sees them: input lines show the pin,
    // outputs the latch; a read-modify-write on a mixed bank thus rewrites
    // input modes from pin levels, so software works on a copy instead
    logic [7:0] level_view_a;
    logic [7:0] level_view_b;

    always_comb begin
        level_view_a = ((bank_a_r.direction & bank_a_r.level)
                       | (~bank_a_r.direction & sync_a_r))
                       & BANK_A_PRESENT;
        level_view_b = ((bank_b_r.direction & bank_b_r.level)
                       | (~bank_b_r.direction & sync_b_r))
                       & BANK_B_PRESENT;
    end

    // read path: registered, so a write in the same cycle is not seen yet
    always_comb begin
        rdata_nxt = rdata_r;
        if (bus_rd) begin
            case (bus_addr)
                ADDR_BANK_A_LEVEL: begin
                    rdata_nxt = level_view_a;
                end
                ADDR_BANK_B_LEVEL: begin
                    rdata_nxt = level_view_b;
                end
                ADDR_BANK_A_DIRECTION: begin
                    rdata_nxt = bank_a_r.direction;
                end
                ADDR_BANK_B_DIRECTION: begin
                    rdata_nxt = bank_b_r.direction;
                end
                ADDR_BANK_A_CONFIG: begin
                    rdata_nxt = bank_a_r.config_bits;
                end
                ADDR_BANK_B_CONFIG: begin
                    rdata_nxt = bank_b_r.config_bits;
                end
                default: begin
                    rdata_nxt = UNMAPPED_READ;
                end
            endcase
        end
    end

    // trigger candidates per line; prev is one cycle older than sync
    logic [7:0] low_a;
    logic [7:0] fall_a;
    logic [7:0] rise_b;
    logic [7:0] fall_b;

    // only lines decoded as interrupt inputs may raise a request
    always_comb begin
        low_a = pad_a_r.irq_en & ~sync_a_r;
        fall_a = pad_a_r.irq_en & prev_a_r & ~sync_a_r;
        rise_b = pad_b_r.irq_en & ~prev_b_r & sync_b_r;
        fall_b = pad_b_r.irq_en & prev_b_r & ~sync_b_r;
    end

    // source 1: level request holds while an enabled line stays low;
    // no storage here, the core samples it after each instruction
    always_comb begin
        if (level_edge_select) begin
            irq1_nxt = |low_a;
        end else begin
            irq1_nxt = |fall_a;
        end
    end

    // source 2: one-cycle pulse per edge of the chosen polarity;
    // flipping the polarity while a line moves may lose that edge
    always_comb begin
        if (edge_polarity_select) begin
            irq2_nxt = |rise_b;
        end else begin
            irq2_nxt = |fall_b;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bank_a_r <= '{LEVEL_RESET, DIRECTION_RESET, CONFIG_RESET};
            bank_b_r <= '{LEVEL_RESET, DIRECTION_RESET, CONFIG_RESET};
        end else begin
            bank_a_r <= bank_a_nxt;
            bank_b_r <= bank_b_nxt;
        end
    end

    // reset pads: every line a pull-up input, nothing driven;
    // absent lines get the pull-up too so their pads never float
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pad_a_r <= '{8'h00, 8'h00, BANK_A_PRESENT | 8'hFF, 8'h00, 8'h00};
            pad_b_r <= '{8'h00, 8'h00, BANK_B_PRESENT | 8'hFF, 8'h00, 8'h00};
        end else begin
            pad_a_r <= pad_a_nxt;
            pad_b_r <= pad_b_nxt;
        end
    end

    // prev resets high so a line held high at release is not a false rising edge
    // only the second stage feeds logic; the first may still be settling
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a_meta_r <= 8'hFF;
            sync_a_r <= 8'hFF;
            prev_a_r <= 8'hFF;
            sync_b_meta_r <= 8'hFF;
            sync_b_r <= 8'hFF;
            prev_b_r <= 8'hFF;
        end else begin
            sync_a_meta_r <= bank_a_pin_in;
            sync_a_r <= sync_a_meta_r;
            prev_a_r <= sync_a_r;
            sync_b_meta_r <= bank_b_pin_in;
            sync_b_r <= sync_b_meta_r;
            prev_b_r <= sync_b_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= UNMAPPED_READ;
            irq1_r <= 1'b0;
            irq2_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            irq1_r <= irq1_nxt;
            irq2_r <= irq2_nxt;
        end
    end

    assign bus_rdata = rdata_r;
    assign bank_a_pad = pad_a_r;
    assign bank_b_pad = pad_b_r;
    assign irq_source1 = irq1_r;
    assign irq_source2 = irq2_r;

endmodule

// [dual_bank_io_lines_monitor.sv]
/* concurrent checks on the ports of dual_bank_io_lines
   assumes a bind from the bench top file */
`timescale 1ns/1ps
module io_lines_checker (
    input wire logic ref_clk,                    // core clock
    input wire logic rst,                        // async reset
    input wire logic [7:0] bus_addr,             // address
    input wire logic bus_wr,                     // write strobe
    input wire logic bus_rd,                     // read strobe
    input wire logic [7:0] bus_wdata,            // write data
    input wire logic [7:0] bus_rdata,            // read data
    input wire logic level_edge_select,          // source 1 mode
    input wire io_lines_pkg::pad_ctrl_type bank_a_pad, // bank a pads
    input wire io_lines_pkg::pad_ctrl_type bank_b_pad, // bank b pads
    input wire logic irq_source1,                // source 1 request
    input wire logic irq_source2                 // source 2 request
);
    import io_lines_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_reset_vals: assert property (
        $fell(rst) |-> bank_a_pad == 40'h0000FF0000 && bank_b_pad == 40'h0000FF0000)
        else $error("pads not at reset values");
    chk_out_nopull: assert property (
        bus_wr && bus_addr == ADDR_BANK_A_DIRECTION
        |=> (bank_a_pad.pull_up & $past(bus_wdata)) == 8'h00) else $error("output pulled up");
    chk_out_noirq: assert property (
        bus_wr && bus_addr == ADDR_BANK_B_DIRECTION
        |=> ((bank_b_pad.irq_en | bank_b_pad.analog) & $past(bus_wdata)) == 8'h00)
        else $error("output line left as input");
    chk_unmapped_zero: assert property (
        bus_rd && !(bus_addr inside {8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD})
        |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        !bus_rd |=> $stable(bus_rdata)) else $error("read data moved");
    chk_analog_alone: assert property (
        (bank_b_pad.analog & (bank_b_pad.pull_up | bank_b_pad.drive_en | bank_b_pad.irq_en))
        == 8'h00) else $error("analog line not isolated");
    chk_irq_pullup: assert property (
        ((bank_a_pad.irq_en & ~bank_a_pad.pull_up) | (bank_b_pad.irq_en & ~bank_b_pad.pull_up))
        == 8'h00) else $error("interrupt line without pull-up");
    chk_pulse2_width: assert property (
        irq_source2 |=> !irq_source2) else $error("source 2 pulse too long");
    chk_pulse1_width: assert property (
        !level_edge_select [*2] ##0 irq_source1 |=> !irq_source1)
        else $error("source 1 edge pulse too long");
    cover property (irq_source1 && level_edge_select);
    cover property (irq_source2);
    cover property (bank_b_pad.analog != 8'h00);
endmodule

// [io_pins_model.sv]
/* external circuits on both banks: drivers, pull-ups, floating lines
   assumes pad controls from the block and drive requests from the bench */
`timescale 1ns/1ps
module io_pins_model (
    input wire logic ref_clk,                      // moves floating lines
    input wire io_lines_pkg::pad_ctrl_type pad_a,  // bank a pads
    input wire io_lines_pkg::pad_ctrl_type pad_b,  // bank b pads
    input wire logic [15:0] ext_en,                // outside driver on, b:a
    input wire logic [15:0] ext_val,               // outside driver level
    output logic [7:0] pin_a,                      // bank a levels
    output logic [7:0] pin_b                       // bank b levels
);
    import io_lines_pkg::*;
    logic flt_r = 1'b0;
    // undriven lines wander so a stale level never passes for a real one
    always @(posedge ref_clk) flt_r <= ~flt_r;
    function automatic logic [7:0] lvl(pad_ctrl_type p, logic [7:0] e, logic [7:0] v, logic f);
        return (p.drive_en & p.drive_val) | (~p.drive_en & e & v)
            | (~p.drive_en & ~e & (p.pull_up | {8{f}}));
    endfunction
    assign pin_a = lvl(pad_a, ext_en[7:0], ext_val[7:0], flt_r);
    assign pin_b = lvl(pad_b, ext_en[15:8], ext_val[15:8], flt_r);
endmodule

// [dual_bank_io_lines_tb.sv]
/* bench for dual_bank_io_lines: register tasks, mode table, interrupts
   assumes io_pins_model on the pins and the checker bound below */
`timescale 1ns/1ps
module dual_bank_io_lines_tb;
    import io_lines_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata, pin_a, pin_b;
    logic level_edge_select = 1'b0;
    logic edge_polarity_select = 1'b0;
    logic [15:0] ext_en = 16'h0000;
    logic [15:0] ext_val = 16'h0000;
    pad_ctrl_type pad_a, pad_b;
    logic irq1, irq2;
    int num_errors = 0;
    int num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    dual_bank_io_lines i_dut (.ref_clk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
        .bus_rdata, .level_edge_select, .edge_polarity_select, .bank_a_pin_in(pin_a),
        .bank_b_pin_in(pin_b), .bank_a_pad(pad_a), .bank_b_pad(pad_b), .irq_source1(irq1),
        .irq_source2(irq2));
    io_pins_model i_pins (.ref_clk, .pad_a, .pad_b, .ext_en, .ext_val, .pin_a, .pin_b);
    task automatic give_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(negedge ref_clk);
        check(40'(bus_rdata), 40'(e));
    endtask
    task automatic pins(input logic s1, input logic s2, input logic [15:0] en, input logic [15:0] v);
        @(posedge ref_clk);
        level_edge_select <= s1;
        edge_polarity_select <= s2;
        ext_en <= en;
        ext_val <= v;
    endtask
    task automatic wait_irq(input bit src, input logic exp);
        int n;
        n = 0;
        while ((src ? irq2 : irq1) !== exp && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check(40'(src ? irq2 : irq1), 40'(exp));
        // a timeout has already been counted by the compare above
        if ((src ? irq2 : irq1) !== exp) give_verdict();
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check(pad_a, 40'h0000FF0000);
        check(pad_b, 40'h0000FF0000);
        rd(ADDR_BANK_A_DIRECTION, DIRECTION_RESET);
        rd(ADDR_BANK_B_CONFIG, CONFIG_RESET);
        rd(ADDR_BANK_A_LEVEL, 8'hFF);
        wr(8'hC3, 8'hFF);
        rd(8'hC3, UNMAPPED_READ);
        wr(ADDR_BANK_A_DIRECTION, 8'hFF);
        wr(ADDR_BANK_A_LEVEL, 8'hA5);
        wr(ADDR_BANK_A_CONFIG, 8'hFF);
        // push-pull: all lines driven, value is the latch
        check(pad_a, 40'hFFA5000000);
        rd(ADDR_BANK_A_LEVEL, 8'hA5);
        wr(ADDR_BANK_A_CONFIG, 8'h00);
        // open drain: only low latch bits sink, nothing driven high
        check(pad_a, 40'h5A00000000);
        wr(ADDR_BANK_B_DIRECTION, 8'hF0);
        wr(ADDR_BANK_B_CONFIG, 8'hCC);
        wr(ADDR_BANK_B_LEVEL, 8'hAA);
        // lines 0..7: pull-up, hi-z, irq, analog, od low, od off, pp low, pp high
        check(pad_b, 40'hD080050804);
        pins(1'b0, 1'b0, 16'h0F00, 16'h0900);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_BANK_B_LEVEL, 8'hA9);
        pins(1'b0, 1'b1, 16'h0F00, 16'h0D00);
        wait_irq(1'b1, 1'b1);
        pins(1'b0, 1'b0, 16'h0F00, 16'h0900);
        wait_irq(1'b1, 1'b1);
        wr(ADDR_BANK_A_DIRECTION, 8'h00);
        wr(ADDR_BANK_A_LEVEL, 8'h00);
        wr(ADDR_BANK_A_CONFIG, 8'h01);
        pins(1'b1, 1'b0, 16'h0F03, 16'h0902);
        wait_irq(1'b0, 1'b1);
        repeat (5) @(negedge ref_clk);
        check(40'(irq1), 40'h1);
        pins(1'b1, 1'b0, 16'h0F03, 16'h0903);
        wait_irq(1'b0, 1'b0);
        pins(1'b0, 1'b0, 16'h0F03, 16'h0901);
        repeat (6) @(negedge ref_clk);
        check(40'(irq1), 40'h0);
        pins(1'b0, 1'b0, 16'h0F03, 16'h0900);
        wait_irq(1'b0, 1'b1);
        give_verdict();
    end
endmodule
bind dual_bank_io_lines io_lines_checker u_chk (.ref_clk, .rst, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .level_edge_select, .bank_a_pad, .bank_b_pad, .irq_source1,
    .irq_source2);
